// *** hw/pes_regs.svh ***
`ifndef PES_REGS_SVH
`define PES_REGS_SVH

// ==========================================================================
// register offsets inside the power-event block (system I/O space)
`define PES_OFS_EVENT_STATUS     8'h01
`define PES_OFS_RSVD_ENABLE_LOW  8'h02
`define PES_OFS_EVENT_ENABLE     8'h03
`define PES_OFS_MASTER_CONTROL   8'h04
`define PES_OFS_SLEEP_CONTROL    8'h05
`define PES_OFS_GEN_STATUS       8'h08
`define PES_OFS_GEN_ENABLE       8'h09
`define PES_OFS_WAKE_STATUS      8'h10
`define PES_OFS_WAKE_ENABLE      8'h11

// ==========================================================================
// field positions
`define PES_BIT_BUTTON           0
`define PES_BIT_ALARM            2
`define PES_BIT_OVERRIDE_FLAG    3
`define PES_BIT_SCI_MASTER       0
`define PES_BIT_OVERRIDE_EN      1
`define PES_BIT_SLEEP_TYPE_LO    2
`define PES_BIT_SLEEP_TYPE_HI    4
`define PES_BIT_SLEEP_TRIGGER    5
`define PES_BIT_PME              0

// ==========================================================================
// reset values and encodings
`define PES_RESET_BYTE           8'h00
`define PES_SLEEP_TYPE_OFF       3'h0

// ==========================================================================
// timing: system clock, rtc tick and button override hold time
`define PES_CLK_PERIOD_NS        50
`define PES_RTC_PERIOD_NS        31250
`define PES_TICK_CYCLES          (`PES_RTC_PERIOD_NS / `PES_CLK_PERIOD_NS)
`define PES_OVERRIDE_TIME_MS     4000
`define PES_OVERRIDE_CYCLES      ((64'd`PES_OVERRIDE_TIME_MS * 64'd1000000) / 64'd`PES_CLK_PERIOD_NS)

`endif

// *** hw/pes_pkg.sv ***
package pes_pkg;

    // ======================================================================
    // power sequencing states
    typedef enum logic [1:0] {
        PES_PWR_ON   = 2'b00,
        PES_PWR_ARM  = 2'b01,
        PES_PWR_WAIT = 2'b10,
        PES_PWR_OFF  = 2'b11
    } pes_pwr_t;

    // ======================================================================
    // host access to the register block, one request per cycle
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pes_io_req_t;

    // ======================================================================
    // state of the event block, apart from the rtc tick divider
    typedef struct packed {
        logic       btnEn;
        logic       alarmEn;
        logic       sciMaster;
        logic       ovrEn;
        logic [2:0] sleepType;
        logic       btnFlag;
        logic       alarmFlag;
        logic       ovrFlag;
        logic       pmeSumFlag;
        logic       pmeSciEn;
        logic       wakeFlag;
        logic       wakeOutEn;
        logic       sleepSmiFlag;
        logic       smi;
        pes_pwr_t   pwr;
        logic       btnPrev;
        logic [7:0] srcPrev;
        logic [26:0] ovrCount;
        logic       ovrDone;
        logic [7:0] rdata;
    } pes_state_t;

    // ======================================================================
    // rtc tick divider state
    typedef struct packed {
        logic [9:0] count;
        logic       tick;
    } pes_tick_t;

endpackage

// *** hw/pes_rtc_tick.sv ***
`timescale 1ns/1ps
`include "pes_regs.svh"

module pes_rtc_tick (
    input  wire logic mclk,
    input  wire logic reset_n,
    output logic      rtcTick
);

    localparam logic [9:0] TICK_LAST = 10'(`PES_TICK_CYCLES - 1);

    pes_pkg::pes_tick_t st;
    pes_pkg::pes_tick_t next_st;

    // ======================================================================
    // free-running divider, one pulse per rtc period
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.count == TICK_LAST) begin
            next_st.count = 10'h000;
            next_st.tick  = 1'b1;
        end else begin
            next_st.count = st.count + 10'h001;
        end
    end

    // ======================================================================
    // state register
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rtcTick = st.tick;

endmodule

// *** hw/pes_power_event.sv ***
`timescale 1ns/1ps
`include "pes_regs.svh"

module pes_power_event #(
    parameter longint unsigned OVERRIDE_CYCLES = `PES_OVERRIDE_CYCLES
) (
    input  wire logic                 mclk,
    input  wire logic                 reset_n,
    input  wire pes_pkg::pes_io_req_t ioReq,
    output logic [7:0]                ioRdata,
    input  wire logic                 buttonInput,
    input  wire logic                 rtcAlarm,
    input  wire logic [7:0]           pmeSource,
    input  wire logic                 sleepRedirectSelect,
    input  wire logic                 sleepSmiClear,
    output logic                      sci,
    output logic                      smi,
    output logic                      sleepSmiFlag,
    output logic                      powerOnNOut,
    output logic                      powerOnNOe,
    output logic                      pmeReqNOut,
    output logic                      pmeReqNOe
);

    localparam logic [26:0] OVR_LAST = 27'(OVERRIDE_CYCLES);

    pes_pkg::pes_state_t st;
    pes_pkg::pes_state_t next_st;
    logic                rtcTick;
    logic [7:0]          srcRise;
    logic                wakePending;
    logic                btnRise;
    logic                wrEvStatus;
    logic                wrEvEnable;
    logic                wrMaster;
    logic                wrSleep;
    logic                wrGenStatus;
    logic                wrGenEnable;
    logic                wrWakeStatus;
    logic                wrWakeEnable;
    logic                triggerWrite;

    // ======================================================================
    // rtc-rate tick for the sleep delay
    // free-running, so the first tick after a write may come at once
    pes_rtc_tick u_tick (
        .mclk    (mclk),
        .reset_n (reset_n),
        .rtcTick (rtcTick)
    );

    // ======================================================================
    // per-source rising edges; a held source level sets nothing
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_src
            assign srcRise[gi] = pmeSource[gi] & ~st.srcPrev[gi];
        end
    endgenerate

    // a source still high counts as a pending wake event,
    // which is what blocks the summary and wake flag clears
    assign wakePending = |pmeSource;
    assign btnRise     = buttonInput & ~st.btnPrev;

    // ======================================================================
    // address decode of write strobes
    // host strobes last one cycle, so each write acts exactly once
    assign wrEvStatus   = ioReq.wr && (ioReq.addr == `PES_OFS_EVENT_STATUS);
    assign wrEvEnable   = ioReq.wr && (ioReq.addr == `PES_OFS_EVENT_ENABLE);
    assign wrMaster     = ioReq.wr && (ioReq.addr == `PES_OFS_MASTER_CONTROL);
    assign wrSleep      = ioReq.wr && (ioReq.addr == `PES_OFS_SLEEP_CONTROL);
    assign wrGenStatus  = ioReq.wr && (ioReq.addr == `PES_OFS_GEN_STATUS);
    assign wrGenEnable  = ioReq.wr && (ioReq.addr == `PES_OFS_GEN_ENABLE);
    assign wrWakeStatus = ioReq.wr && (ioReq.addr == `PES_OFS_WAKE_STATUS);
    assign wrWakeEnable = ioReq.wr && (ioReq.addr == `PES_OFS_WAKE_ENABLE);
    assign triggerWrite = wrSleep && ioReq.wdata[`PES_BIT_SLEEP_TRIGGER];

    // ======================================================================
    // next-state logic of the block, apart from the rtc tick divider
    always_comb begin
        next_st = st;
        next_st.smi     = 1'b0;
        next_st.btnPrev = buttonInput;
        next_st.srcPrev = pmeSource;

        // enable and control registers; only defined bits are stored
        if (wrEvEnable) begin
            next_st.btnEn   = ioReq.wdata[`PES_BIT_BUTTON];
            next_st.alarmEn = ioReq.wdata[`PES_BIT_ALARM];
        end
        if (wrMaster) begin
            next_st.sciMaster = ioReq.wdata[`PES_BIT_SCI_MASTER];
        end
        if (wrSleep) begin
            next_st.ovrEn     = ioReq.wdata[`PES_BIT_OVERRIDE_EN];
            next_st.sleepType = ioReq.wdata[`PES_BIT_SLEEP_TYPE_HI:`PES_BIT_SLEEP_TYPE_LO];
        end
        if (wrGenEnable) begin
            next_st.pmeSciEn = ioReq.wdata[`PES_BIT_PME];
        end
        if (wrWakeEnable) begin
            next_st.wakeOutEn = ioReq.wdata[`PES_BIT_PME];
        end

        // write-one clears first, so a same-cycle hardware set wins below;
        // an event landing with a clear must never be lost to the host
        if (wrEvStatus && ioReq.wdata[`PES_BIT_BUTTON]) begin
            next_st.btnFlag = 1'b0;
        end
        if (wrEvStatus && ioReq.wdata[`PES_BIT_ALARM]) begin
            next_st.alarmFlag = 1'b0;
        end
        if (wrEvStatus && ioReq.wdata[`PES_BIT_OVERRIDE_FLAG]) begin
            next_st.ovrFlag = 1'b0;
        end
        if (wrGenStatus && ioReq.wdata[`PES_BIT_PME] && !wakePending) begin
            next_st.pmeSumFlag = 1'b0;
        end
        if (wrWakeStatus && ioReq.wdata[`PES_BIT_PME] && !wakePending) begin
            next_st.wakeFlag = 1'b0;
        end
        if (sleepSmiClear) begin
            next_st.sleepSmiFlag = 1'b0;
        end

        // hardware sets
        if (btnRise) begin
            next_st.btnFlag = 1'b1;
        end
        if (rtcAlarm) begin
            next_st.alarmFlag = 1'b1;
        end
        if (|srcRise) begin
            next_st.pmeSumFlag = 1'b1;
            next_st.wakeFlag   = 1'b1;
        end
        if (triggerWrite) begin
            next_st.sleepSmiFlag = 1'b1;
        end

        // button hold timer; restarts on every release. the override fires
        // once per hold, so a button kept down after power-off does not
        // re-arm it; the 27-bit count bounds the longest hold time
        if (!buttonInput) begin
            next_st.ovrCount = 27'h0000000;
            next_st.ovrDone  = 1'b0;
        end else if (!st.ovrDone) begin
            if (st.ovrCount == OVR_LAST) begin
                // held longer than the override time
                next_st.ovrDone = 1'b1;
                if (st.ovrEn && st.pwr != pes_pkg::PES_PWR_OFF) begin
                    next_st.btnFlag = 1'b0;
                    next_st.ovrFlag = 1'b1;
                    next_st.pwr     = pes_pkg::PES_PWR_OFF;
                end
            end else begin
                next_st.ovrCount = st.ovrCount + 27'h0000001;
            end
        end

        // a redirected trigger answers with a management interrupt in any
        // power state, so software never waits on a sleep that cannot come
        if (triggerWrite && sleepRedirectSelect) begin
            next_st.smi = 1'b1;
        end

        // sleep sequencing; waits for the second rtc tick after the write.
        // two ticks instead of a fixed count keep the release inside the
        // one-to-two period window wherever the divider stands
        case (st.pwr)
            pes_pkg::PES_PWR_ON: begin
                // only the off type acts; other sleep types are ignored
                if (triggerWrite && !sleepRedirectSelect &&
                    ioReq.wdata[`PES_BIT_SLEEP_TYPE_HI:`PES_BIT_SLEEP_TYPE_LO]
                    == `PES_SLEEP_TYPE_OFF) begin
                    next_st.pwr = pes_pkg::PES_PWR_ARM;
                end
            end
            pes_pkg::PES_PWR_ARM: begin
                if (rtcTick) begin
                    next_st.pwr = pes_pkg::PES_PWR_WAIT;
                end
            end
            pes_pkg::PES_PWR_WAIT: begin
                if (rtcTick) begin
                    next_st.pwr = pes_pkg::PES_PWR_OFF;
                end
            end
            pes_pkg::PES_PWR_OFF: begin
                // a fresh button press always wakes the machine
                if (btnRise) begin
                    next_st.pwr = pes_pkg::PES_PWR_ON;
                end
            end
            default: begin
                next_st.pwr = pes_pkg::PES_PWR_ON;
            end
        endcase

        // read data, registered; unmapped offsets read zero. the byte
        // holds between reads, so a late sampling host still sees it
        if (ioReq.rd) begin
            case (ioReq.addr)
                `PES_OFS_EVENT_STATUS: begin
                    next_st.rdata = `PES_RESET_BYTE;
                    next_st.rdata[`PES_BIT_BUTTON]        = st.btnFlag;
                    next_st.rdata[`PES_BIT_ALARM]         = st.alarmFlag;
                    next_st.rdata[`PES_BIT_OVERRIDE_FLAG] = st.ovrFlag;
                end
                `PES_OFS_EVENT_ENABLE: begin
                    next_st.rdata = `PES_RESET_BYTE;
                    next_st.rdata[`PES_BIT_BUTTON] = st.btnEn;
                    next_st.rdata[`PES_BIT_ALARM]  = st.alarmEn;
                end
                `PES_OFS_MASTER_CONTROL: begin
                    next_st.rdata = `PES_RESET_BYTE;
                    next_st.rdata[`PES_BIT_SCI_MASTER] = st.sciMaster;
                end
                `PES_OFS_SLEEP_CONTROL: begin
                    // trigger bit is not stored, so it reads zero
                    next_st.rdata = `PES_RESET_BYTE;
                    next_st.rdata[`PES_BIT_OVERRIDE_EN] = st.ovrEn;
                    next_st.rdata[`PES_BIT_SLEEP_TYPE_HI:`PES_BIT_SLEEP_TYPE_LO] =
                        st.sleepType;
                end
                `PES_OFS_GEN_STATUS: begin
                    next_st.rdata = `PES_RESET_BYTE;
                    next_st.rdata[`PES_BIT_PME] = st.pmeSumFlag;
                end
                `PES_OFS_GEN_ENABLE: begin
                    next_st.rdata = `PES_RESET_BYTE;
                    next_st.rdata[`PES_BIT_PME] = st.pmeSciEn;
                end
                `PES_OFS_WAKE_STATUS: begin
                    next_st.rdata = `PES_RESET_BYTE;
                    next_st.rdata[`PES_BIT_PME] = st.wakeFlag;
                end
                `PES_OFS_WAKE_ENABLE: begin
                    next_st.rdata = `PES_RESET_BYTE;
                    next_st.rdata[`PES_BIT_PME] = st.wakeOutEn;
                end
                default: begin
                    next_st.rdata = `PES_RESET_BYTE;
                end
            endcase
        end
    end

    // ======================================================================
    // state register; reset clears every flag and enable
    // all-zero state also means powered on, with the power pin driven
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ======================================================================
    // interrupt and pin outputs
    assign sci = st.sciMaster &
                 ((st.btnFlag & st.btnEn) |
                  (st.alarmFlag & st.alarmEn) |
                  (st.pmeSumFlag & st.pmeSciEn));
    assign smi          = st.smi;
    assign sleepSmiFlag = st.sleepSmiFlag;
    assign ioRdata      = st.rdata;

    // open-drain pins pull low while enabled, float otherwise; the data
    // side is tied low, so only the enables move. the power pin is not
    // sensed back, so a board holding it low goes unnoticed
    assign powerOnNOut = 1'b0;
    assign powerOnNOe  = (st.pwr != pes_pkg::PES_PWR_OFF);
    assign pmeReqNOut  = 1'b0;
    assign pmeReqNOe   = st.wakeFlag & st.wakeOutEn;

endmodule

// *** sim/pes_power_event_monitor.sv ***
`timescale 1ns/1ps

// ==========================================================================
// port-level checker for the power-event block
module pes_power_event_monitor #(
    parameter longint unsigned OVERRIDE_CYCLES = 50
) (
    input wire logic                 mclk,
    input wire logic                 reset_n,
    input wire pes_pkg::pes_io_req_t ioReq,
    input wire logic [7:0]           ioRdata,
    input wire logic                 buttonInput,
    input wire logic                 rtcAlarm,
    input wire logic [7:0]           pmeSource,
    input wire logic                 sleepRedirectSelect,
    input wire logic                 sleepSmiClear,
    input wire logic                 sci,
    input wire logic                 smi,
    input wire logic                 sleepSmiFlag,
    input wire logic                 powerOnNOut,
    input wire logic                 powerOnNOe,
    input wire logic                 pmeReqNOut,
    input wire logic                 pmeReqNOe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // shorthand for a trigger write to the sleep control byte
    logic trigWr;
    assign trigWr = ioReq.wr && ioReq.addr == 8'h05 && ioReq.wdata[5];

    // ======================================================================
    // register read-back and sleep sequencing
    property p_rsvd_rd; ioReq.rd && ioReq.addr == 8'h02 |=> ioRdata == 8'h00; endproperty
    a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved byte not zero");
    property p_trig_rd; ioReq.rd && ioReq.addr == 8'h05 |=> ioRdata[7:5] == 3'h0; endproperty
    a_trig_rd: assert property (p_trig_rd) else $error("trigger bit read back");
    property p_redir; trigWr && sleepRedirectSelect |=> smi; endproperty
    a_redir: assert property (p_redir) else $error("no smi on redirect");
    property p_smi_src; smi |-> $past(trigWr && sleepRedirectSelect); endproperty
    a_smi_src: assert property (p_smi_src) else $error("smi without cause");
    property p_smi_flag; trigWr |=> sleepSmiFlag; endproperty
    a_smi_flag: assert property (p_smi_flag) else $error("smi flag not set");
    // cycles since an off-type trigger while the power pin is still driven;
    // the release window is too wide for a delay range, so it is counted
    logic [10:0] sleepCnt;
    always_ff @(posedge mclk) begin
        if (!reset_n || !powerOnNOe) begin
            sleepCnt <= 11'h000;
        end else if (sleepCnt != 11'h000) begin
            sleepCnt <= sleepCnt + 11'h001;
        end else if (trigWr && ioReq.wdata[4:2] == 3'h0 && !sleepRedirectSelect) begin
            sleepCnt <= 11'h001;
        end
    end
    property p_sleep_off; sleepCnt != 11'h000 |-> sleepCnt <= 11'h4E3; endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("power pin not released");
    property p_sleep_win;
        $fell(powerOnNOe) && sleepCnt != 11'h000 |-> sleepCnt >= 11'h273;
    endproperty
    a_sleep_win: assert property (p_sleep_win) else $error("power pin released too soon");
    property p_sleep_early;
        trigWr && !sleepRedirectSelect && powerOnNOe |=> powerOnNOe [*8];
    endproperty
    a_sleep_early: assert property (p_sleep_early) else $error("power pin released early");
    // ======================================================================
    // interrupt gating and wake request
    property p_master; ioReq.wr && ioReq.addr == 8'h04 && !ioReq.wdata[0] |=> !sci; endproperty
    a_master: assert property (p_master) else $error("sci with master off");
    property p_wake_dis; ioReq.wr && ioReq.addr == 8'h11 && !ioReq.wdata[0] |=> !pmeReqNOe;
    endproperty
    a_wake_dis: assert property (p_wake_dis) else $error("wake request while disabled");
    property p_wake_clr;
        ioReq.wr && ioReq.addr == 8'h10 && ioReq.wdata[0] && pmeSource == 8'h00 |=> !pmeReqNOe;
    endproperty
    a_wake_clr: assert property (p_wake_clr) else $error("wake request not released");
endmodule

bind pes_power_event pes_power_event_monitor #(.OVERRIDE_CYCLES(OVERRIDE_CYCLES)) u_mon (
    .mclk(mclk), .reset_n(reset_n), .ioReq(ioReq), .ioRdata(ioRdata),
    .buttonInput(buttonInput), .rtcAlarm(rtcAlarm), .pmeSource(pmeSource),
    .sleepRedirectSelect(sleepRedirectSelect), .sleepSmiClear(sleepSmiClear), .sci(sci),
    .smi(smi), .sleepSmiFlag(sleepSmiFlag), .powerOnNOut(powerOnNOut),
    .powerOnNOe(powerOnNOe), .pmeReqNOut(pmeReqNOut), .pmeReqNOe(pmeReqNOe));

// *** sim/pes_board_model.sv ***
`timescale 1ns/1ps

// ==========================================================================
// board side of the open-drain pins: pull-ups hold a released line high
module pes_board_model (
    input  wire logic powerOnNOut,
    input  wire logic powerOnNOe,
    input  wire logic pmeReqNOut,
    input  wire logic pmeReqNOe,
    output logic      powerOnPin,
    output logic      pmeReqPin
);
    // a floating pin must read high, never the last driven value
    assign powerOnPin = powerOnNOe ? powerOnNOut : 1'b1;
    assign pmeReqPin  = pmeReqNOe ? pmeReqNOut : 1'b1;
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ps

module tb_top;
    localparam int OVR = 50;
    logic                 mclk      = 1'b0;
    logic                 reset_n   = 1'b0;
    pes_pkg::pes_io_req_t ioReq     = '0;
    logic                 buttonInput = 1'b0;
    logic                 rtcAlarm  = 1'b0;
    logic [7:0]           pmeSource = 8'h00;
    logic                 sleepRedirectSelect = 1'b0;
    logic                 sleepSmiClear = 1'b0;
    logic [7:0]           ioRdata;
    logic                 sci, smi, sleepSmiFlag, powerOnNOut, powerOnNOe;
    logic                 pmeReqNOut, pmeReqNOe, powerOnPin, pmeReqPin;
    int                   mismatches = 0;
    int                   compares = 0;
    int                   seed = 41582;
    int                   n;
    // reference model of the register contents
    logic [7:0]           mEn, mMaster, mCtl, mStat, mSum, mGen, mWake, mWakeEn;
    logic [7:0]           rwTab [6] = '{8'h02, 8'h03, 8'h04, 8'h09, 8'h11, 8'h01};

    pes_power_event #(.OVERRIDE_CYCLES(OVR)) pes_power_event_inst (
        .mclk(mclk), .reset_n(reset_n), .ioReq(ioReq), .ioRdata(ioRdata),
        .buttonInput(buttonInput), .rtcAlarm(rtcAlarm), .pmeSource(pmeSource),
        .sleepRedirectSelect(sleepRedirectSelect), .sleepSmiClear(sleepSmiClear),
        .sci(sci), .smi(smi), .sleepSmiFlag(sleepSmiFlag), .powerOnNOut(powerOnNOut),
        .powerOnNOe(powerOnNOe), .pmeReqNOut(pmeReqNOut), .pmeReqNOe(pmeReqNOe));
    pes_board_model pes_board_model_inst (
        .powerOnNOut(powerOnNOut), .powerOnNOe(powerOnNOe), .pmeReqNOut(pmeReqNOut),
        .pmeReqNOe(pmeReqNOe), .powerOnPin(powerOnPin), .pmeReqPin(pmeReqPin));

    // ======================================================================
    // clock
    initial begin
        forever #25 mclk = ~mclk;
    end

    // ======================================================================
    // helpers: every input change lands 1 ns after a rising edge
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // a bus strobe stays up until the next plain wait drops it
    task automatic cyc(input int k);
        ioReq = '0;
        repeat (k) @(posedge mclk);
        #1;
    endtask
    function automatic logic [7:0] expRd(input logic [7:0] a);
        case (a)
            8'h01: return mStat;
            8'h03: return mEn;
            8'h04: return mMaster;
            8'h05: return mCtl;
            8'h08: return mSum;
            8'h09: return mGen;
            8'h10: return mWake;
            8'h11: return mWakeEn;
            default: return 8'h00;
        endcase
    endfunction
    // sci and wake request as the model predicts them
    task automatic pins();
        logic s;
        s = mMaster[0] & ((|(mStat & mEn & 8'h05)) | (mSum[0] & mGen[0]));
        chk({6'h0, sci, ~pmeReqPin}, {6'h0, s, mWakeEn[0] & mWake[0]}, "sci/wake pins");
    endtask
    task automatic rd(input logic [7:0] a);
        ioReq = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge mclk);
        #1;
        chk(ioRdata, expRd(a), "read data");
    endtask
    // write strobe plus model update; a pending wake source blocks the summary and wake clears
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ioReq = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge mclk);
        #1;
        case (a)
            8'h01: mStat = mStat & ~(d & 8'h0D);
            8'h03: mEn = d & 8'h05;
            8'h04: mMaster = d & 8'h01;
            8'h05: mCtl = d & 8'h1E;
            8'h08: if (d[0] && pmeSource == 8'h00) mSum = 8'h00;
            8'h09: mGen = d & 8'h01;
            8'h10: if (d[0] && pmeSource == 8'h00) mWake = 8'h00;
            8'h11: mWakeEn = d & 8'h01;
            default: ;
        endcase
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ======================================================================
    // scenarios
    initial begin
        {mEn, mMaster, mCtl, mStat, mSum, mGen, mWake, mWakeEn} = '0;
        cyc(10);
        reset_n = 1'b1;
        for (int a = 0; a < 18; a++) rd(8'(a));
        chk({7'h0, powerOnPin}, 8'h00, "power on after reset");
        pins();
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            wr(rwTab[i % 6], 8'($random(seed)));
            rd(rwTab[i % 6]);
            pins();
        end
        $display("test register access done");
        wr(8'h04, 8'h01);
        wr(8'h03, 8'h00);
        buttonInput = 1'b1;
        cyc(3);
        buttonInput = 1'b0;
        cyc(2);
        mStat[0] = 1'b1;
        rd(8'h01);
        pins();
        wr(8'h03, 8'h01);
        pins();
        wr(8'h01, 8'h00);
        rd(8'h01);
        rtcAlarm = 1'b1;
        cyc(1);
        rtcAlarm = 1'b0;
        cyc(2);
        mStat[2] = 1'b1;
        pins();
        wr(8'h03, 8'h05);
        wr(8'h01, 8'h01);
        rd(8'h01);
        pins();
        wr(8'h04, 8'h00);
        pins();
        wr(8'h01, 8'h04);
        rd(8'h01);
        $display("test button alarm done");
        wr(8'h04, 8'h01);
        wr(8'h09, 8'h00);
        wr(8'h11, 8'h00);
        pmeSource = 8'h01 << ($random(seed) & 7);
        cyc(3);
        mSum = 8'h01;
        mWake = 8'h01;
        rd(8'h08);
        rd(8'h10);
        pins();
        wr(8'h08, 8'h01);
        wr(8'h10, 8'h01);
        rd(8'h08);
        rd(8'h10);
        wr(8'h09, 8'h01);
        wr(8'h11, 8'h01);
        pins();
        pmeSource = 8'h00;
        cyc(2);
        rd(8'h10);
        wr(8'h10, 8'h01);
        pins();
        wr(8'h08, 8'h01);
        rd(8'h08);
        pins();
        $display("test wake events done");
        sleepRedirectSelect = 1'b1;
        wr(8'h05, 8'h20);
        chk({6'h0, smi, sleepSmiFlag}, 8'h03, "redirected trigger");
        sleepSmiClear = 1'b1;
        cyc(1);
        sleepSmiClear = 1'b0;
        cyc(1300);
        chk({6'h0, sleepSmiFlag, powerOnPin}, 8'h00, "no sleep");
        sleepRedirectSelect = 1'b0;
        wr(8'h05, 8'h24);
        cyc(1300);
        chk({6'h0, sleepSmiFlag, powerOnPin}, 8'h02, "other type");
        rd(8'h05);
        wr(8'h05, 8'h20);
        n = 1;
        while (powerOnPin === 1'b0 && n < 1400) begin
            cyc(1);
            n++;
        end
        if (n >= 1400) begin
            mismatches++;
            $display("BAD %0t power pin never released", $time);
            stop_test();
        end
        chk({7'h0, n >= 626 && n <= 1251}, 8'h01, "sleep delay");
        buttonInput = 1'b1;
        cyc(2);
        buttonInput = 1'b0;
        cyc(2);
        mStat[0] = 1'b1;
        chk({7'h0, powerOnPin}, 8'h00, "button wakes");
        $display("test sleep done");
        wr(8'h01, 8'h0D);
        wr(8'h05, 8'h02);
        buttonInput = 1'b1;
        cyc(OVR + 10);
        mStat = 8'h08;
        chk({7'h0, powerOnPin}, 8'h01, "override off");
        rd(8'h01);
        buttonInput = 1'b0;
        cyc(2);
        buttonInput = 1'b1;
        cyc(2);
        buttonInput = 1'b0;
        cyc(2);
        mStat = 8'h09;
        rd(8'h01);
        chk({7'h0, powerOnPin}, 8'h00, "override recovered");
        $display("test override done");
        stop_test();
    end
endmodule
